// ==== inc/tag_brk_pkg.sv ====
// Constants and register map of the tag breakpoint controller
`default_nettype none
package tag_brk_pkg;
  localparam int NCH = 4;
  localparam int QDEPTH = 3;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CHCFG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  // Control register bit positions
  localparam int B_ARM = 0;
  localparam int B_SOFT = 1;
  localparam int B_BRKEN = 2;
  localparam int B_TOBGND = 3;
  localparam int B_ALIGN = 4;
  localparam int B_TRCSRC = 6;
  // Channel config: per channel nibble, bit positions within it
  localparam int CH_EN = 0;
  localparam int CH_TAG = 1;
  localparam int CH_IMM = 2;
  localparam int CH_STRIDE = 4;
  // Status bit positions
  localparam int S_FINAL = 0;
  localparam int S_TRACE = 1;
  localparam int S_PEND = 2;
  localparam int S_SWI = 3;
  localparam int S_ENTER_BACKGROUND_INSTRUCTION = 4;
  localparam int S_LINES = 8;
  // Alignment codes
  localparam logic [1:0] AL_END = 2'h0;
  localparam logic [1:0] AL_BEGIN = 2'h1;
  localparam logic [1:0] AL_MID = 2'h2;
  // Trace line counts
  localparam logic [5:0] POST_LINES = 6'h20;
  localparam logic [6:0] BUF_LINES = 7'h40;
  // AXI responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== rtl/tag_breakpoint_control.sv ====
// Tag breakpoint controller with AXI4-Lite register slave
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`default_nettype none
// Overview of operation
// - Tags ride instruction queue, hit at head
// - Per-channel tag select: immediate or tagged
// - Begin alignment: tag hit starts trace, break later
// - Mid alignment: 32 more lines, then break
// - End alignment: break at once on tag
// - Tagged channel ignores access and data qualifiers
// - Tagged ranges resolved only to word granularity
// - No tagging while background mode active
// - Breaks from comparator final state or soft bit
// - Halt command ignored in stop or wait
// - Trace selected: break after session, else immediate
// - Immediate-break bit stops trace, breaks now
// - Alignment field selects trace window
// - Break-enable bit gates every break request
// - Soft bit forces final state, even disarmed
// - Later triggers ignored once tracing session started
// - Breaks blocked while background firmware runs
// - No tag entry into background during trace command
// - Route break to software interrupt or background
// - Background request beats coinciding software interrupt
// - Unserviced pending break reasserted after return
module tag_breakpoint_control (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // AXI4-Lite write address, data and response
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Comparators and instruction queue
  input wire logic [3:0] chMatch,
  input wire logic [3:0] chMatchWord,
  input wire logic opFetch,
  input wire logic opExec,
  input wire logic queueFlush,
  input wire logic traceStore,
  // Core and background debug status
  input wire logic bgndActive,
  input wire logic bgndEnabled,
  input wire logic bgndTraceCmd,
  input wire logic stopWait,
  input wire logic haltCmd,
  input wire logic brkAck,
  // Requests to the core
  output logic reqSwi,
  output logic reqBgnd,
  output logic haltReq,
  output logic traceOn
);
  typedef struct packed {
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic armed;
    logic softReq;
    logic brkEn;
    logic toBgnd;
    logic [1:0] align;
    logic trcSrc;
    logic [3:0] chEn;
    logic [3:0] chTag;
    logic [3:0] chImm;
    logic finalSt;
    logic tracing;
    logic [5:0] postCnt;
    logic [6:0] lineCnt;
    logic pend;
    logic reqSwi;
    logic reqBgnd;
    logic haltReq;
    logic [tag_brk_pkg::QDEPTH-1:0][3:0] tagQ;
    logic [1:0] qCnt;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic softHit;
  logic tagHit;
  logic [3:0] trigCh;
  logic soft_trigger_bit;
  logic doWr;

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  always_comb begin
    logic [3:0] head;
    logic [3:0] newTag;
    logic done;
    logic pop;
    head = s_q.tagQ[0];
    newTag = 4'h0;
    done = 1'b0;
    pop = 1'b0;
    s_d = s_q;
    // Bus write channel capture, either order
    if (!s_q.awHave && awvalid) begin
      s_d.awHave = 1'b1;
      s_d.awAddr = awaddr;
    end
    if (!s_q.wHave && wvalid) begin
      s_d.wHave = 1'b1;
      s_d.wData = wdata;
      s_d.wStrb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    doWr = s_q.awHave && s_q.wHave && !s_q.bvalid;
    // Soft trigger acts one cycle after its write, so it sees the new control bits
    softHit = s_q.softReq;
    s_d.softReq = 1'b0;
    if (doWr) begin
      s_d.awHave = 1'b0;
      s_d.wHave = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = tag_brk_pkg::RESP_OK;
      case (s_q.awAddr)
        tag_brk_pkg::OFF_CTRL: begin
          if (s_q.wStrb[0]) begin
            s_d.armed = s_q.wData[tag_brk_pkg::B_ARM];
            s_d.softReq = s_q.wData[tag_brk_pkg::B_SOFT];
            s_d.brkEn = s_q.wData[tag_brk_pkg::B_BRKEN];
            s_d.toBgnd = s_q.wData[tag_brk_pkg::B_TOBGND];
            s_d.align = s_q.wData[tag_brk_pkg::B_ALIGN +: 2];
            s_d.trcSrc = s_q.wData[tag_brk_pkg::B_TRCSRC];
          end
        end
        tag_brk_pkg::OFF_CHCFG: begin
          for (int c = 0; c < tag_brk_pkg::NCH; c++) begin
            if (s_q.wStrb[c/2]) begin
              s_d.chEn[c] = s_q.wData[c*tag_brk_pkg::CH_STRIDE+tag_brk_pkg::CH_EN];
              s_d.chTag[c] = s_q.wData[c*tag_brk_pkg::CH_STRIDE+tag_brk_pkg::CH_TAG];
              s_d.chImm[c] = s_q.wData[c*tag_brk_pkg::CH_STRIDE+tag_brk_pkg::CH_IMM];
            end
          end
        end
        tag_brk_pkg::OFF_STATUS: ;
        default: s_d.bresp = tag_brk_pkg::RESP_SLVERR;
      endcase
    end
    // Bus read: one cycle after address taken
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arready && arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = tag_brk_pkg::RESP_OK;
      s_d.rdata = 32'h0;
      case (araddr)
        tag_brk_pkg::OFF_CTRL: begin
          s_d.rdata[tag_brk_pkg::B_ARM] = s_q.armed;
          s_d.rdata[tag_brk_pkg::B_BRKEN] = s_q.brkEn;
          s_d.rdata[tag_brk_pkg::B_TOBGND] = s_q.toBgnd;
          s_d.rdata[tag_brk_pkg::B_ALIGN +: 2] = s_q.align;
          s_d.rdata[tag_brk_pkg::B_TRCSRC] = s_q.trcSrc;
        end
        tag_brk_pkg::OFF_CHCFG: begin
          for (int c = 0; c < tag_brk_pkg::NCH; c++) begin
            s_d.rdata[c*tag_brk_pkg::CH_STRIDE+tag_brk_pkg::CH_EN] = s_q.chEn[c];
            s_d.rdata[c*tag_brk_pkg::CH_STRIDE+tag_brk_pkg::CH_TAG] = s_q.chTag[c];
            s_d.rdata[c*tag_brk_pkg::CH_STRIDE+tag_brk_pkg::CH_IMM] = s_q.chImm[c];
          end
        end
        tag_brk_pkg::OFF_STATUS: begin
          s_d.rdata[tag_brk_pkg::S_FINAL] = s_q.finalSt;
          s_d.rdata[tag_brk_pkg::S_TRACE] = s_q.tracing;
          s_d.rdata[tag_brk_pkg::S_PEND] = s_q.pend;
          s_d.rdata[tag_brk_pkg::S_SWI] = s_q.reqSwi;
          s_d.rdata[tag_brk_pkg::S_ENTER_BACKGROUND_INSTRUCTION] = s_q.reqBgnd;
          s_d.rdata[tag_brk_pkg::S_LINES +: 7] = s_q.lineCnt;
        end
        default: s_d.rresp = tag_brk_pkg::RESP_SLVERR;
      endcase
    end
    // Tagged channels use the address-only word match, qualifiers ignored
    newTag = s_q.chEn & s_q.chTag & chMatchWord;
    // Tag popped at queue head when the instruction is about to execute
    pop = opExec && (s_q.qCnt != 2'h0);
    tagHit = pop && s_q.armed && !bgndActive && !bgndTraceCmd && (head != 4'h0);
    // Queue of tags riding alongside fetched opcodes
    if (queueFlush) begin
      s_d.qCnt = 2'h0;
      s_d.tagQ = '0;
    end else begin
      if (pop) begin
        for (int i = 0; i < tag_brk_pkg::QDEPTH - 1; i++) begin
          s_d.tagQ[i] = s_q.tagQ[i+1];
        end
        s_d.tagQ[tag_brk_pkg::QDEPTH-1] = 4'h0;
        s_d.qCnt = s_q.qCnt - 2'h1;
      end
      if (opFetch && s_d.qCnt != 2'(tag_brk_pkg::QDEPTH)) begin
        s_d.tagQ[s_d.qCnt] = (bgndActive || !s_q.armed) ? 4'h0 : newTag;
        s_d.qCnt = s_d.qCnt + 2'h1;
      end
    end
    // Untagged channels trigger directly on a qualified match
    trigCh = (s_q.armed ? (s_q.chEn & ~s_q.chTag & chMatch) : 4'h0)
             | (tagHit ? head : 4'h0);
    soft_trigger_bit = (trigCh != 4'h0) || softHit;
    // Pre-trigger tracing runs from arming for end and mid alignment
    if (s_q.armed && !s_q.finalSt && s_q.trcSrc && s_q.align != tag_brk_pkg::AL_BEGIN) begin
      s_d.tracing = 1'b1;
    end
    if (!s_q.armed && !s_q.finalSt) begin
      s_d.tracing = 1'b0;
    end
    // Transition to final state; ignored once already final
    if (soft_trigger_bit && !s_q.finalSt) begin
      s_d.finalSt = 1'b1;
      s_d.lineCnt = 7'h0;
      if (!s_q.trcSrc || (trigCh & s_q.chImm) != 4'h0) begin
        s_d.tracing = 1'b0;
        s_d.pend = s_q.brkEn;
        s_d.armed = 1'b0;
      end else begin
        case (s_q.align)
          tag_brk_pkg::AL_BEGIN: begin
            s_d.tracing = 1'b1;
          end
          tag_brk_pkg::AL_MID: begin
            s_d.tracing = 1'b1;
            s_d.postCnt = tag_brk_pkg::POST_LINES;
          end
          default: begin
            s_d.tracing = 1'b0;
            s_d.pend = s_q.brkEn;
            s_d.armed = 1'b0;
          end
        endcase
      end
    end
    // Trace session progress after the trigger
    done = 1'b0;
    if (s_q.finalSt && s_q.tracing && traceStore) begin
      s_d.lineCnt = s_q.lineCnt + 7'h1;
      if (s_q.align == tag_brk_pkg::AL_MID) begin
        s_d.postCnt = s_q.postCnt - 6'h1;
        done = (s_q.postCnt == 6'h1);
      end else begin
        done = (s_q.lineCnt == tag_brk_pkg::BUF_LINES - 7'h1);
      end
    end
    if (done) begin
      s_d.tracing = 1'b0;
      s_d.pend = s_q.brkEn;
      s_d.armed = 1'b0;
    end
    // Leave final state once disarmed and no session remains
    if (s_q.finalSt && !s_q.armed && !s_q.tracing && !soft_trigger_bit) begin
      s_d.finalSt = 1'b0;
    end
    // Breakpoint routing; pending break is held across background mode
    s_d.reqSwi = 1'b0;
    s_d.reqBgnd = 1'b0;
    if (s_q.pend) begin
      if (!s_q.brkEn || brkAck) begin
        s_d.pend = 1'b0;
      end else if (!bgndActive) begin
        if (s_q.toBgnd && bgndEnabled) begin
          s_d.reqBgnd = 1'b1;
        end else begin
          s_d.reqSwi = 1'b1;
        end
      end
    end
    s_d.haltReq = haltCmd && !stopWait;
  end

  //----------------------------------------------------------------
  // State register
  //----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign awready = !s_q.awHave;
  assign wready = !s_q.wHave;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = !s_q.rvalid;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign reqSwi = s_q.reqSwi;
  assign reqBgnd = s_q.reqBgnd;
  assign haltReq = s_q.haltReq;
  assign traceOn = s_q.tracing;

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  a_halt_stop: assert property (@(posedge mclk) disable iff (!rstn)
    haltCmd && stopWait |=> !haltReq) else $error("halt passed in stop");
  a_enter_background_instruction_block: assert property (@(posedge mclk) disable iff (!rstn)
    bgndActive |=> !reqSwi && !reqBgnd) else $error("break during background");
  a_tag_enter_background_instruction: assert property (@(posedge mclk) disable iff (!rstn)
    (bgndActive || bgndTraceCmd) |-> !tagHit) else $error("tag hit in background");
  a_soft_final: assert property (@(posedge mclk) disable iff (!rstn)
    softHit |=> s_q.finalSt) else $error("soft trigger lost");
  a_mid_count: assert property (@(posedge mclk) disable iff (!rstn)
    soft_trigger_bit && !s_q.finalSt && s_q.trcSrc && s_q.align == tag_brk_pkg::AL_MID
    && (trigCh & s_q.chImm) == 4'h0 |=> s_q.postCnt == tag_brk_pkg::POST_LINES && s_q.tracing)
    else $error("mid count not loaded");
  a_imm_break: assert property (@(posedge mclk) disable iff (!rstn)
    soft_trigger_bit && !s_q.finalSt && s_q.brkEn && (trigCh & s_q.chImm) != 4'h0 |=> s_q.pend && !s_q.tracing)
    else $error("immediate break missing");
  a_route_enter_background_instruction: assert property (@(posedge mclk) disable iff (!rstn)
    s_q.pend && s_q.brkEn && !brkAck && !bgndActive && s_q.toBgnd && bgndEnabled
    |=> reqBgnd && !reqSwi) else $error("background route wrong");
  a_no_brken: assert property (@(posedge mclk) disable iff (!rstn)
    !s_q.brkEn |=> !reqSwi && !reqBgnd) else $error("break without enable");
  a_final_hold: assert property (@(posedge mclk) disable iff (!rstn)
    s_q.finalSt && s_q.tracing && soft_trigger_bit |=> s_q.finalSt && !s_q.pend) else $error("retrigger acted");
  // A tag hit at the queue head always lands in the final state
  a_tag_final: assert property (@(posedge mclk) disable iff (!rstn)
    tagHit |=> s_q.finalSt) else $error("tag hit lost");
  // End alignment with tracing breaks at once, before the instruction runs
  a_end_break: assert property (@(posedge mclk) disable iff (!rstn)
    soft_trigger_bit && !s_q.finalSt && s_q.trcSrc && s_q.brkEn && s_q.align == tag_brk_pkg::AL_END
    && (trigCh & s_q.chImm) == 4'h0 |=> s_q.pend && !s_q.tracing)
    else $error("end break missing");
  // Begin alignment starts the session and holds the break back
  a_begin_trace: assert property (@(posedge mclk) disable iff (!rstn)
    soft_trigger_bit && !s_q.finalSt && s_q.trcSrc && s_q.align == tag_brk_pkg::AL_BEGIN
    && (trigCh & s_q.chImm) == 4'h0 |=> s_q.tracing && s_q.finalSt)
    else $error("begin trace not started");
  // Without background routing a pending break goes to the software interrupt
  a_route_swi: assert property (@(posedge mclk) disable iff (!rstn)
    s_q.pend && s_q.brkEn && !brkAck && !bgndActive && !(s_q.toBgnd && bgndEnabled)
    |=> reqSwi && !reqBgnd) else $error("swi route wrong");
endmodule
`default_nettype wire

// ==== verification/core_model.sv ====
// Behavioural core queue and debug link facing the breakpoint controller
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Bench controls
  input wire logic fetchGo,
  input wire logic [3:0] tagChan,
  input wire logic slowAck,
  // Controller requests
  input wire logic reqSwi,
  input wire logic reqBgnd,
  input wire logic traceOn,
  // Queue and trace events
  output logic opFetch,
  output logic opExec,
  output logic [3:0] chMatchWord,
  output logic traceStore,
  output logic brkAck
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] pipe;
  int held;
  // Opcode fetch with word match, execution once it reaches the head; ack taken late or soon
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pipe <= 3'h0;
      opFetch <= 1'b0;
      opExec <= 1'b0;
      chMatchWord <= 4'h0;
      traceStore <= 1'b0;
      brkAck <= 1'b0;
      held <= 0;
    end else begin
      opFetch <= fetchGo;
      chMatchWord <= fetchGo ? tagChan : 4'h0;
      pipe <= {pipe[1:0], fetchGo};
      opExec <= pipe[2];
      traceStore <= traceOn;
      held <= ((reqSwi || reqBgnd) && !brkAck) ? held + 1 : 0;
      brkAck <= (reqSwi || reqBgnd) && !brkAck && held == (slowAck ? 8 : 2);
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_tag_breakpoint_control.sv ====
// Self-checking bench of the tag breakpoint controller
`default_nettype none
module tb_tag_breakpoint_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rstn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, opFetch, opExec, queueFlush, traceStore, bgndActive, bgndEnabled;
  logic bgndTraceCmd, stopWait, haltCmd, brkAck, reqSwi, reqBgnd, haltReq, traceOn;
  logic fetchGo, slowAck;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, chMatch, chMatchWord, tagChan;
  logic [1:0] bresp, rresp;
  int bad_count = 0;
  int check_count = 0;
  int cycNow = 0;

  tag_breakpoint_control u_dut (.mclk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .chMatch, .chMatchWord, .opFetch, .opExec, .queueFlush, .traceStore,
    .bgndActive, .bgndEnabled, .bgndTraceCmd, .stopWait, .haltCmd, .brkAck, .reqSwi,
    .reqBgnd, .haltReq, .traceOn);
  core_model u_core (.mclk, .rstn, .fetchGo, .tagChan, .slowAck, .reqSwi, .reqBgnd,
    .traceOn, .opFetch, .opExec, .chMatchWord, .traceStore, .brkAck);

  // Clock, cycle count and watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cycNow <= cycNow + 1;
  initial begin
    #100us;
    bad_count++;
    stop_test();
  end

  // -----------------------------
  // Bus and check tasks
  // -----------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (50) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (50) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic fire(input logic [3:0] ch);
    tagChan <= ch;
    fetchGo <= 1'b1;
    @(posedge mclk);
    fetchGo <= 1'b0;
  endtask
  task automatic waitReq(input int lim, output int n);
    n = 0;
    while (!(reqSwi || reqBgnd) && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask
  // Configure, fetch a tagged opcode on channel 0 and check the request kind
  task automatic tagRun(input logic [31:0] cfg, input logic [31:0] ctl, input logic [1:0] e);
    int n;
    axw(tag_brk_pkg::OFF_CHCFG, cfg);
    axw(tag_brk_pkg::OFF_CTRL, ctl);
    fire(4'h1);
    waitReq(20, n);
    chk(32'({reqBgnd, reqSwi}), 32'(e), "route");
    repeat (15) @(posedge mclk);
  endtask

  // -----------------------------
  // Tests
  // -----------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    int t0;
    {awvalid, wvalid, bready, arvalid, rready, fetchGo, slowAck, queueFlush} = '0;
    {bgndActive, bgndEnabled, bgndTraceCmd, stopWait, haltCmd} = '0;
    {awaddr, araddr, wdata, wstrb, chMatch, tagChan} = '0;
    rstn = 1'b0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    axr(tag_brk_pkg::OFF_STATUS, d, r);
    chk(d, 32'h0, "status");
    axr(8'h0c, d, r);
    chk(32'(r), 32'(tag_brk_pkg::RESP_SLVERR), "unmapped");
    tagRun(32'h3, 32'h05, 2'b01);
    tagRun(32'h3, 32'h01, 2'b00);
    tagRun(32'h1, 32'h05, 2'b00);
    tagRun(32'h7, 32'h55, 2'b01);
    tagRun(32'h0, 32'h06, 2'b01);
    bgndEnabled <= 1'b1;
    tagRun(32'h3, 32'h0d, 2'b10);
    bgndTraceCmd <= 1'b1;
    tagRun(32'h3, 32'h0d, 2'b00);
    bgndTraceCmd <= 1'b0;
    // Request withdrawn in background mode, raised again on return
    slowAck <= 1'b1;
    fire(4'h1);
    waitReq(20, n);
    bgndActive <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(32'({reqBgnd, reqSwi}), 32'h0, "blocked");
    bgndActive <= 1'b0;
    waitReq(6, n);
    chk(32'(reqBgnd), 32'h1, "reassert");
    repeat (15) @(posedge mclk);
    slowAck <= 1'b0;
    bgndEnabled <= 1'b0;
    tagRun(32'h3, 32'h0d, 2'b01);
    // Qualified match counts only for untagged channels
    for (int i = 0; i < 2; i++) begin
      axw(tag_brk_pkg::OFF_CHCFG, 32'(1 + 2 * i));
      axw(tag_brk_pkg::OFF_CTRL, 32'h05);
      chMatch <= 4'h1;
      @(posedge mclk);
      chMatch <= 4'h0;
      waitReq(20, n);
      chk(32'(reqSwi), 32'(1 - i), "match");
      repeat (15) @(posedge mclk);
    end
    // Tag fetched in background mode is dropped
    axw(tag_brk_pkg::OFF_CTRL, 32'h05);
    bgndActive <= 1'b1;
    fire(4'h1);
    repeat (6) @(posedge mclk);
    bgndActive <= 1'b0;
    waitReq(20, n);
    chk(32'(reqSwi), 32'h0, "tag in enter_background_instruction");
    // Mid then begin alignment with tracing, late soft trigger ignored
    axw(tag_brk_pkg::OFF_CHCFG, 32'h3);
    axw(tag_brk_pkg::OFF_CTRL, 32'h65);
    fire(4'h1);
    t0 = cycNow;
    waitReq(100, n);
    chk(32'(cycNow - t0 >= 34 && cycNow - t0 <= 44), 32'h1, "mid");
    repeat (15) @(posedge mclk);
    axw(tag_brk_pkg::OFF_CTRL, 32'h55);
    fire(4'h1);
    t0 = cycNow;
    repeat (30) @(posedge mclk);
    axw(tag_brk_pkg::OFF_CTRL, 32'h57);
    waitReq(100, n);
    chk(32'(cycNow - t0 >= 66 && cycNow - t0 <= 78), 32'h1, "begin");
    // Halt command masked in stop or wait
    haltCmd <= 1'b1;
    stopWait <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(32'(haltReq), 32'h0, "halt stop");
    stopWait <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(32'(haltReq), 32'h1, "halt");
    stop_test();
  end
endmodule
`default_nettype wire
